// >>> rtl/hrtd_measure.v
/*
  timing diagram measurement engine: parameter registers, command decode,
  sequencer restart per cycle of each test, comparator edge sweep, result store.
  assumes sequencer, timing setup and comparator front end outside, on clk_in;
  pin level inputs are asynchronous and synchronised here.
*/
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "hrtd_defs.vh"

// Summary of operation
// - sample dut levels evenly across the period in edge compare mode, sweeping edge.
// - restart the sequencer at the start label once for every cycle of every test.
// - timing may be modified during measurement; originals restored at end.
// - measurement start finishes with one functional test in acquire mode.
// - device clear aborts, restores setup, and skips the closing functional test.
// - limits query reports max pins and max samples, samples fixed at 1024.
// - pin maximum is 32, or 4 on the smallest small-memory configuration.
// - parameter readback answered only by the master mainframe.
// - cycles is an integer above zero, counted in 100 MHz sequencer cycles.
// - cycle offset names the first cycle, signed, from the delay counter.
// - samples-per-cycle above zero; sample offset within 0 to spc minus samples.
// - reject parameters when cycles below 1, product above 1024, samples too big.
// - tests performed equal samples; any error except non-applicable pins leaves no results.
// - start error on no acquire mode, missing cycles, over 32 pins, bad pins.
// - with non-applicable pins, results still kept for applicable pins.
// - result query gives latest run, or line-feed only when none since set.
// - result line omitted for pins whose configuration changed.
// - characters 0, 1, I, ?; I and ? never for fast pins.
// - result line is pin name, hash, digit string, result characters.
// - sampling starts only on measurement start with pin list; rest stored.
module hrtd_measure (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire [3:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  input  wire        master_in,
  input  wire        small_cfg_in,
  input  wire        acquire_mode_in,
  input  wire [15:0] avail_cycles_in,
  input  wire [31:0] bad_pins_in,
  input  wire [31:0] fast_pins_in,
  input  wire [31:0] above_hi_in,
  input  wire [31:0] below_lo_in,
  input  wire        seq_done_in,
  input  wire        func_done_in,
  output reg         seq_restart_out,
  output reg  [15:0] seq_cycle_out,
  output reg         edge_mode_out,
  output reg  [31:0] edge_delay_out,
  output reg         timing_restore_out,
  output reg         func_test_out,
  output reg         acquire_mode_out
);
  // ==========================================
  // state codes
  localparam ST_IDLE = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_CAPT = 3'h3;
  localparam ST_REST = 3'h4;
  localparam ST_FUNC = 3'h5;

  reg [2:0]  state;
  reg [15:0] cycles;
  reg [15:0] cyc_ofs;
  reg [15:0] spc;
  reg [15:0] samples;
  reg [15:0] smp_ofs;
  reg [31:0] pinlist;
  reg [31:0] meas_pins;
  reg [31:0] cfg_changed;
  reg [9:0]  res_sel;
  reg [7:0]  status;
  reg [15:0] test_idx;
  reg [15:0] cyc_idx;
  reg [31:0] pins_sync1;
  reg [31:0] pins_sync2;
  reg [31:0] lo_sync1;
  reg [31:0] lo_sync2;
  reg [63:0] store [0:1023];
  reg [9:0]  pin_count;
  integer    i;

  wire        range_err;
  wire [31:0] delay;
  wire [5:0]  pin_max;
  wire [16:0] last_cycle;
  wire        cmd_wr;
  wire [2:0]  cmd;
  wire [15:0] next_test_idx;
  wire        abort_hit;

  hrtd_param_check u_check (
    .cycles_in     ((wdata_in[31:16] != 16'h0000) ? wdata_in[31:16] : cycles),
    .spc_in        (spc),
    .samples_in    (samples),
    .smp_ofs_in    (smp_ofs),
    .range_err_out (range_err)
  );

  hrtd_edge_calc u_edge (
    .index_in  (smp_ofs + next_test_idx),
    .spc_in    (spc),
    .delay_out (delay)
  );

  assign pin_max    = small_cfg_in ? `HRTD_PINS_SMALL : `HRTD_PINS_LARGE;
  assign last_cycle = {cyc_ofs[15], cyc_ofs} + {1'b0, cycles};
  assign cmd_wr     = wr_in && (addr_in == `HRTD_A_CMD);
  assign cmd        = wdata_in[2:0];

  // ==========================================
  // derived controls
  // edge for the coming test is worked out ahead so it lands with the restart
  assign next_test_idx = (state == ST_CAPT) ? test_idx + 16'h0001 : 16'h0000;
  // clear is honoured until the closing test has been issued
  assign abort_hit     = cmd_wr && (cmd == `HRTD_C_DEV_CLEAR) &&
                         (state == ST_LOAD || state == ST_RUN ||
                          state == ST_CAPT || state == ST_REST);

  // count of set bits, used for pin list limit
  function [9:0] ones;
    input [31:0] v;
    integer k;
    begin
      ones = 10'h000;
      for (k = 0; k < 32; k = k + 1)
        ones = ones + {9'h000, v[k]};
    end
  endfunction

  // four-valued level code per pin, fast pins forced to clean levels
  function [1:0] level;
    input hi;
    input lo;
    input fast;
    begin
      if (fast)
        level = {1'b0, hi};
      else
        level = {hi == lo, hi};
    end
  endfunction

  function [7:0] to_char;
    input [1:0] c;
    begin
      case (c)
        2'h0:    to_char = `HRTD_CH_LOW;
        2'h1:    to_char = `HRTD_CH_HIGH;
        2'h2:    to_char = `HRTD_CH_MID;
        default: to_char = `HRTD_CH_BAD;
      endcase
    end
  endfunction

  // ==========================================
  // level input synchronisers
  always @(posedge clk_in) begin
    pins_sync1 <= above_hi_in;
    pins_sync2 <= pins_sync1;
    lo_sync1   <= below_lo_in;
    lo_sync2   <= lo_sync1;
  end

  // ==========================================
  // parameters, commands and sequencing
  always @(posedge clk_in) begin
    seq_restart_out    <= 1'b0;
    timing_restore_out <= 1'b0;
    func_test_out      <= 1'b0;
    if (reset_in) begin
      state            <= ST_IDLE;
      cycles           <= 16'h0001;
      cyc_ofs          <= 16'h0000;
      spc              <= 16'h0001;
      samples          <= 16'h0001;
      smp_ofs          <= 16'h0000;
      pinlist          <= 32'h00000000;
      meas_pins        <= 32'h00000000;
      cfg_changed      <= 32'h00000000;
      res_sel          <= 10'h000;
      status           <= 8'h00;
      test_idx         <= 16'h0000;
      cyc_idx          <= 16'h0000;
      pin_count        <= 10'h000;
      edge_mode_out    <= 1'b0;
      edge_delay_out   <= 32'h00000000;
      seq_cycle_out    <= 16'h0000;
      acquire_mode_out <= 1'b0;
    end else begin
      if (wr_in && state == ST_IDLE) begin
        case (addr_in)
          `HRTD_A_CYCLES:  cycles  <= wdata_in[15:0];
          `HRTD_A_CYC_OFS: cyc_ofs <= wdata_in[15:0];
          `HRTD_A_SPC:     spc     <= wdata_in[15:0];
          `HRTD_A_SAMPLES: samples <= wdata_in[15:0];
          `HRTD_A_SMP_OFS: smp_ofs <= wdata_in[15:0];
          `HRTD_A_PINLIST: pinlist <= wdata_in;
          default: ;
        endcase
      end
      if (wr_in && addr_in == `HRTD_A_RES_SEL)
        res_sel <= wdata_in[9:0];
      // configuration change marks; a new measurement clears them
      if (wr_in && addr_in == `HRTD_A_CFG_CHG)
        cfg_changed <= cfg_changed | wdata_in;
      case (state)
        ST_IDLE: begin
          if (cmd_wr && cmd == `HRTD_C_PARAM_SET) begin
            // the cycles field travels with the command word
            status[`HRTD_S_RANGE_ERR] <= range_err;
            status[`HRTD_S_VALID]     <= 1'b0;
            if (!range_err)
              cycles <= wdata_in[31:16] == 16'h0000 ? cycles : wdata_in[31:16];
          end else if (cmd_wr && cmd == `HRTD_C_MEAS_START) begin
            pin_count <= ones(pinlist);
            test_idx  <= 16'h0000;
            cyc_idx   <= 16'h0000;
            state     <= ST_LOAD;
          end
        end

        ST_LOAD: begin
          status[`HRTD_S_START_ERR] <= 1'b0;
          status[`HRTD_S_ABORTED]   <= 1'b0;
          if (!acquire_mode_in ||
              last_cycle[16] == 1'b0 && last_cycle[15:0] > avail_cycles_in ||
              last_cycle[16] ||
              pin_count > {4'h0, pin_max} ||
              status[`HRTD_S_RANGE_ERR]) begin
            status[`HRTD_S_START_ERR] <= 1'b1;
            status[`HRTD_S_VALID]     <= 1'b0;
            state                     <= ST_IDLE;
          end else begin
            if ((pinlist & bad_pins_in) != 32'h00000000)
              status[`HRTD_S_START_ERR] <= 1'b1;
            meas_pins      <= pinlist & ~bad_pins_in;
            cfg_changed    <= 32'h00000000;
            test_idx       <= 16'h0000;
            status[`HRTD_S_BUSY]  <= 1'b1;
            status[`HRTD_S_SWEEP] <= 1'b1;
            edge_mode_out  <= 1'b1;
            edge_delay_out <= delay;
            seq_restart_out <= 1'b1;
            cyc_idx        <= 16'h0000;
            state          <= ST_RUN;
          end
        end

        ST_RUN: begin
          // one sequencer pass per cycle of each test, one stored word per pass
          seq_cycle_out <= cyc_ofs + cyc_idx;
          if (seq_done_in)
            state <= ST_CAPT;
        end

        ST_CAPT: begin
          for (i = 0; i < 32; i = i + 1)
            store[cyc_idx[9:0] * samples[9:0] + test_idx[9:0]][2*i +: 2] <=
              level(pins_sync2[i], lo_sync2[i], fast_pins_in[i]);
          if (cyc_idx + 16'h0001 < cycles) begin
            cyc_idx         <= cyc_idx + 16'h0001;
            seq_restart_out <= 1'b1;
            state           <= ST_RUN;
          end else if (test_idx + 16'h0001 < samples) begin
            test_idx        <= test_idx + 16'h0001;
            cyc_idx         <= 16'h0000;
            edge_delay_out  <= delay;
            seq_restart_out <= 1'b1;
            state           <= ST_RUN;
          end else begin
            state <= ST_REST;
          end
        end

        ST_REST: begin
          edge_mode_out         <= 1'b0;
          timing_restore_out    <= 1'b1;
          status[`HRTD_S_SWEEP] <= 1'b0;
          status[`HRTD_S_FUNC]  <= 1'b1;
          status[`HRTD_S_VALID] <= 1'b1;
          acquire_mode_out      <= 1'b1;
          func_test_out         <= 1'b1;
          state                 <= ST_FUNC;
        end

        ST_FUNC: begin
          if (func_done_in) begin
            status[`HRTD_S_BUSY] <= 1'b0;
            status[`HRTD_S_FUNC] <= 1'b0;
            acquire_mode_out     <= 1'b0;
            state                <= ST_IDLE;
          end
        end

        default: state <= ST_IDLE;
      endcase
      // device clear beats everything until the closing test has been issued
      if (abort_hit) begin
        // the closing test is skipped, so acquire mode is dropped with it
        edge_mode_out         <= 1'b0;
        acquire_mode_out      <= 1'b0;
        timing_restore_out    <= 1'b1;
        func_test_out         <= 1'b0;
        status                <= 8'h00;
        status[`HRTD_S_ABORTED] <= 1'b1;
        seq_restart_out       <= 1'b0;
        state                 <= ST_IDLE;
      end
    end
  end

  // ==========================================
  // register read port, data one cycle after strobe
  always @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `HRTD_A_CYCLES:  rdata_out <= master_in ? {16'h0000, cycles}  : 32'h00000000;
        `HRTD_A_CYC_OFS: rdata_out <= master_in ? {16'h0000, cyc_ofs} : 32'h00000000;
        `HRTD_A_SPC:     rdata_out <= master_in ? {16'h0000, spc}     : 32'h00000000;
        `HRTD_A_SAMPLES: rdata_out <= master_in ? {16'h0000, samples} : 32'h00000000;
        `HRTD_A_SMP_OFS: rdata_out <= master_in ? {16'h0000, smp_ofs} : 32'h00000000;
        `HRTD_A_STATUS:  rdata_out <= {24'h000000, status};
        `HRTD_A_LIMITS:  rdata_out <= {10'h000, pin_max, `HRTD_MAX_POINTS};
        `HRTD_A_PINLIST: rdata_out <= status[`HRTD_S_VALID] ? meas_pins & ~cfg_changed
                                                          : 32'h00000000;
        `HRTD_A_RES_DATA: rdata_out <= !status[`HRTD_S_VALID] ?
                            {24'h000000, `HRTD_CH_LF} :
                            {to_char(store[res_sel][1:0]), to_char(store[res_sel][3:2]),
                             to_char(store[res_sel][5:4]), to_char(store[res_sel][7:6])};
        `HRTD_A_CFG_CHG: rdata_out <= cfg_changed;
        default:         rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
endmodule // hrtd_measure

// >>> rtl/hrtd_defs.vh
/*
  shared constants of the timing diagram measurement block: command codes,
  register offsets, limits, field positions and result characters.
  assumes inclusion by bare name from every design file of the block.
*/
`ifndef HRTD_DEFS_VH
`define HRTD_DEFS_VH

// ==========================================
// register offsets (word index on the plain port)
`define HRTD_A_CYCLES      4'h0
`define HRTD_A_CYC_OFS     4'h1
`define HRTD_A_SPC         4'h2
`define HRTD_A_SAMPLES     4'h3
`define HRTD_A_SMP_OFS     4'h4
`define HRTD_A_CMD         4'h5
`define HRTD_A_STATUS      4'h6
`define HRTD_A_LIMITS      4'h7
`define HRTD_A_PINLIST     4'h8
`define HRTD_A_RES_SEL     4'h9
`define HRTD_A_RES_DATA    4'hA
`define HRTD_A_CFG_CHG     4'hB

// ==========================================
// command codes written to the command register
`define HRTD_C_PARAM_SET   3'h1
`define HRTD_C_MEAS_START  3'h2
`define HRTD_C_DEV_CLEAR   3'h3

// ==========================================
// limits
`define HRTD_MAX_POINTS    16'h0400
`define HRTD_PINS_LARGE    6'h20
`define HRTD_PINS_SMALL    6'h04
`define HRTD_PERIOD_NS     16'h000A
`define HRTD_PROBE_CYC     16'h0010

// ==========================================
// status bits
`define HRTD_S_BUSY        0
`define HRTD_S_RANGE_ERR   1
`define HRTD_S_START_ERR   2
`define HRTD_S_VALID       3
`define HRTD_S_ABORTED     4
`define HRTD_S_SWEEP       5
`define HRTD_S_FUNC        6

// ==========================================
// result characters
`define HRTD_CH_LOW        8'h30
`define HRTD_CH_HIGH       8'h31
`define HRTD_CH_MID        8'h49
`define HRTD_CH_BAD        8'h3F
`define HRTD_CH_LF         8'h0A

`endif

// >>> rtl/hrtd_param_check.v
/*
  combinational range check of the sampling parameters.
  assumes unsigned register values from the same clock domain.
*/
`timescale 1ns/10ps
`include "hrtd_defs.vh"

module hrtd_param_check (
  input  wire [15:0] cycles_in,
  input  wire [15:0] spc_in,
  input  wire [15:0] samples_in,
  input  wire [15:0] smp_ofs_in,
  output wire        range_err_out
);
  wire [31:0] product;
  wire [16:0] room;
  assign product = cycles_in * samples_in;
  assign room    = {1'b0, spc_in} - {1'b0, smp_ofs_in};

  // ==========================================
  // range checks
  assign range_err_out = (cycles_in < 16'h0001) ||
                         (product > {16'h0000, `HRTD_MAX_POINTS}) ||
                         (spc_in == 16'h0000) ||
                         room[16] ||
                         ({1'b0, samples_in} > room);
endmodule // hrtd_param_check

// >>> rtl/hrtd_edge_calc.v
/*
  comparator leading edge placement for one sample of a cycle.
  assumes period in ns on the sequencer time base, result in 1/65536 ns units.
*/
`timescale 1ns/10ps
`include "hrtd_defs.vh"

module hrtd_edge_calc (
  input  wire [15:0] index_in,
  input  wire [15:0] spc_in,
  output wire [31:0] delay_out
);
  wire [47:0] num;
  assign num = {index_in, 32'h00000000} / {32'h00000000, (spc_in == 16'h0000) ? 16'h0001 : spc_in};
  // ==========================================
  // k times period over samples-per-cycle
  wire [63:0] scaled;
  assign scaled    = num * {32'h00000000, `HRTD_PERIOD_NS};
  assign delay_out = scaled[47:16];
endmodule // hrtd_edge_calc

// >>> bench/hrtd_measure_asserts.sv
/*
  port checker for the timing diagram measurement block.
  assumes a bind onto hrtd_measure and a single clock domain.
*/
`timescale 1ns/10ps
`include "hrtd_defs.vh"

module hrtd_asserts (
  input wire        clk_in,
  input wire        reset_in,
  input wire [3:0]  addr_in,
  input wire [31:0] wdata_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [31:0] rdata_out,
  input wire        master_in,
  input wire        small_cfg_in,
  input wire        seq_restart_out,
  input wire        edge_mode_out,
  input wire        timing_restore_out,
  input wire        func_test_out,
  input wire        acquire_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ==========================================
  // helpers: start seen, sweep in progress
  reg armed;
  reg running;
  wire cmd_wr  = wr_in && addr_in == `HRTD_A_CMD;
  wire clr_w   = cmd_wr && wdata_in[2:0] == `HRTD_C_DEV_CLEAR;
  wire abort_w = clr_w && running;

  always @(posedge clk_in) begin
    if (reset_in) begin
      armed <= 1'b0;
      running <= 1'b0;
    end else begin
      if (cmd_wr && wdata_in[2:0] == `HRTD_C_MEAS_START)
        armed <= 1'b1;
      if (seq_restart_out)
        running <= 1'b1;
      else if (timing_restore_out)
        running <= 1'b0;
    end
  end

  // ==========================================
  // properties
  property p_restart_edge; seq_restart_out && !clr_w |=> edge_mode_out; endproperty
  a_restart_edge: assert property (p_restart_edge)
    else $error("sweep pass without edge compare mode");
  property p_restart_armed; seq_restart_out |-> armed; endproperty
  a_restart_armed: assert property (p_restart_armed)
    else $error("sequencer restarted without a start command");
  property p_restore_edge; timing_restore_out |-> ##[1:2] !edge_mode_out; endproperty
  a_restore_edge: assert property (p_restore_edge)
    else $error("edge mode left on after restore");
  property p_func_restore;
    func_test_out |-> timing_restore_out || $past(timing_restore_out);
  endproperty
  a_func_restore: assert property (p_func_restore)
    else $error("closing test without restored timing");
  property p_func_acq; func_test_out |-> ##[0:1] acquire_mode_out; endproperty
  a_func_acq: assert property (p_func_acq)
    else $error("closing test not in acquire mode");
  property p_abort_restore; abort_w |-> ##[1:3] timing_restore_out; endproperty
  a_abort_restore: assert property (p_abort_restore)
    else $error("abort without restore");
  property p_abort_nofunc; abort_w |=> !func_test_out [*8]; endproperty
  a_abort_nofunc: assert property (p_abort_nofunc)
    else $error("closing test after abort");
  property p_limits;
    rd_in && addr_in == `HRTD_A_LIMITS |=> rdata_out == {10'h000,
      ($past(small_cfg_in) ? `HRTD_PINS_SMALL : `HRTD_PINS_LARGE), `HRTD_MAX_POINTS};
  endproperty
  a_limits: assert property (p_limits)
    else $error("limits word wrong");
  property p_master;
    rd_in && addr_in <= `HRTD_A_SMP_OFS && !master_in |=> rdata_out == 32'h0000_0000;
  endproperty
  a_master: assert property (p_master)
    else $error("readback answered by a slave frame");

  c_abort: cover property (abort_w);
  c_func: cover property (func_test_out);
  c_small: cover property (rd_in && addr_in == `HRTD_A_LIMITS && small_cfg_in);
endmodule // hrtd_asserts

// >>> bench/hrtd_seq_model.sv
/*
  sequencer and functional test front end facing the measurement block.
  assumes single pulses on restart and functional test requests.
*/
`timescale 1ns/10ps

module hrtd_seq_model (
  input  wire clk_in,
  input  wire reset_in,
  input  wire slow_in,
  input  wire seq_restart_in,
  input  wire func_test_in,
  output reg  seq_done_out,
  output reg  func_done_out,
  output int  restart_cnt_out,
  output int  func_cnt_out
);
  // ==========================================
  // pass timers; every pass takes the same time for a given slow_in so tests stay alike
  int wait_q;
  int fwait;

  always @(posedge clk_in) begin
    seq_done_out <= 1'b0;
    func_done_out <= 1'b0;
    if (reset_in) begin
      wait_q <= 0;
      fwait <= 0;
      restart_cnt_out <= 0;
      func_cnt_out <= 0;
    end else begin
      if (seq_restart_in) begin
        wait_q <= slow_in ? 12 : 2;
        restart_cnt_out <= restart_cnt_out + 1;
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
        seq_done_out <= (wait_q == 1);
      end
      if (func_test_in) begin
        fwait <= 3;
        func_cnt_out <= func_cnt_out + 1;
      end else if (fwait > 0) begin
        fwait <= fwait - 1;
        func_done_out <= (fwait == 1);
      end
    end
  end
endmodule // hrtd_seq_model

// >>> bench/hrtd_measure_test.sv
/*
  self-checking bench of the measurement block with a sequencer model.
  assumes the checker is bound from here and a 250 MHz clock.
*/
`timescale 1ns/10ps

module hrtd_measure_test;
  reg         clk_in = 1'b0;
  reg         reset_in = 1'b1;
  reg  [3:0]  addr_in = 4'h0;
  reg  [31:0] wdata_in = 32'h0;
  reg         wr_in = 1'b0, rd_in = 1'b0, master_in = 1'b1, small_cfg_in = 1'b0;
  reg         acquire_mode_in = 1'b1, slow = 1'b0;
  reg  [15:0] avail_cycles_in = 16'hFFFF;
  reg  [31:0] bad_pins_in = 32'h0, above_hi_in = 32'h0, below_lo_in = 32'h0;
  reg  [31:0] fast_pins_in = 32'h0;
  wire [31:0] rdata_out, edge_delay_out;
  wire [15:0] seq_cycle_out;
  wire        seq_done_in, func_done_in, seq_restart_out, edge_mode_out;
  wire        timing_restore_out, func_test_out, acquire_mode_out;
  int         err_total = 0, cmp_count = 0, cyc = 0, rcnt, fcnt;
  int         i, j, r0, f0, c, o, p, s;
  int         rv[5] = '{1, 0, 1, 1, 0};
  int unsigned seed = 27;
  reg  [31:0] st, d;

  always #2 clk_in = ~clk_in;

  hrtd_measure dut_u (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .master_in(master_in), .small_cfg_in(small_cfg_in), .acquire_mode_in(acquire_mode_in),
    .avail_cycles_in(avail_cycles_in), .bad_pins_in(bad_pins_in), .fast_pins_in(fast_pins_in),
    .above_hi_in(above_hi_in), .below_lo_in(below_lo_in), .seq_done_in(seq_done_in),
    .func_done_in(func_done_in), .seq_restart_out(seq_restart_out),
    .seq_cycle_out(seq_cycle_out), .edge_mode_out(edge_mode_out),
    .edge_delay_out(edge_delay_out), .timing_restore_out(timing_restore_out),
    .func_test_out(func_test_out), .acquire_mode_out(acquire_mode_out));

  hrtd_seq_model seq_u (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
    .seq_restart_in(seq_restart_out), .func_test_in(func_test_out),
    .seq_done_out(seq_done_in), .func_done_out(func_done_in),
    .restart_cnt_out(rcnt), .func_cnt_out(fcnt));

  // ==========================================
  // helpers
  function int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function bit perr(int c, int p, int s, int o);
    return c < 1 || c * s > 1024 || s > p - o;
  endfunction

  task wr(input [3:0] a, input [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input [3:0] a, output [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task setp(int c, int o, int p, int s, int so);
    wr(4'h0, c);
    wr(4'h1, o);
    wr(4'h2, p);
    wr(4'h3, s);
    wr(4'h4, so);
    wr(4'h5, 32'h1);
  endtask

  // polling is bounded so a stuck engine still ends the run
  task idle();
    int n;
    n = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 400) begin
      rd(4'h6, st);
      n++;
    end
  endtask

  task test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(i[3:0], st);
      chk(st, rv[i]);
    end
    master_in <= 1'b0;
    rd(4'h0, st);
    chk(st, 0);
    master_in <= 1'b1;
    for (j = 0; j < 2; j++) begin
      small_cfg_in <= j[0];
      rd(4'h7, st);
      chk(st, {(j ? 16'h0004 : 16'h0020), 16'h0400});
    end
    rd(4'hC, st);
    chk(st, 0);
    $display("reset and limits test done");
    for (i = 0; i < 10; i++) begin
      c = xs() % 40;
      p = 1 + xs() % 64;
      o = xs() % p;
      s = 1 + xs() % (p + 2);
      if (i >= 8) begin
        c = 4;
        o = 0;
        p = 248 + i;
        s = p;
      end
      setp(c, o, p, s, o);
      rd(4'h6, st);
      chk(st[1], perr(c, p, s, o));
    end
    rd(4'h3, st);
    chk(st, 257);
    $display("range test done");
    setp(2, 0, 4, 2, 1);
    wr(4'h8, 32'hF);
    above_hi_in <= 32'h9;
    below_lo_in <= 32'hA;
    r0 = rcnt;
    f0 = fcnt;
    wr(4'h5, 32'h2);
    idle();
    chk(st[3], 1);
    chk(st[2], 0);
    chk(rcnt - r0, 4);
    chk(fcnt - f0, 1);
    chk(edge_delay_out, (1 + 1) * 10 * 65536 / 4);
    chk(seq_cycle_out, 1);
    chk(edge_mode_out, 0);
    for (i = 0; i < 4; i++) begin
      wr(4'h9, i);
      rd(4'hA, d);
      chk(d, 32'h3130493F);
    end
    setp(2, 0, 4, 2, 1);
    rd(4'h6, st);
    chk(st[3], 0);
    rd(4'hA, d);
    chk(d, 32'h0000000A);
    $display("measurement test done");
    fast_pins_in <= 32'hC;
    for (j = 0; j < 3; j++) begin
      acquire_mode_in <= (j != 0);
      avail_cycles_in <= (j == 1) ? 16'h0001 : 16'hFFFF;
      bad_pins_in <= {31'h0, j == 2};
      wr(4'h5, 32'h2);
      idle();
      chk(st[2], 1);
    end
    wr(4'h9, 32'h0);
    rd(4'hA, d);
    chk(d[23:16], 8'h30);
    chk(d[15:8] == 8'h49 || d[15:8] == 8'h3F || d[7:0] == 8'h49 || d[7:0] == 8'h3F, 0);
    wr(4'hB, 32'h2);
    rd(4'h8, st);
    chk(st, 32'hC);
    $display("start error test done");
    bad_pins_in <= 32'h0;
    slow <= 1'b1;
    f0 = fcnt;
    wr(4'h5, 32'h2);
    repeat (20) @(posedge clk_in);
    wr(4'h5, 32'h3);
    idle();
    chk(st[4], 1);
    chk(st[3], 0);
    chk(fcnt - f0, 0);
    $display("abort test done");
    test_done();
  end
endmodule // hrtd_measure_test

bind hrtd_measure hrtd_asserts chk_u (.clk_in(clk_in), .reset_in(reset_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .master_in(master_in), .small_cfg_in(small_cfg_in),
  .seq_restart_out(seq_restart_out), .edge_mode_out(edge_mode_out),
  .timing_restore_out(timing_restore_out), .func_test_out(func_test_out),
  .acquire_mode_out(acquire_mode_out));
